// ---- inc/kwi_pkg.sv ----
// keypad wake interrupt unit: register map, field layout and reset values
package kwi_pkg;

  // ---------------------------------------------------------------
  // geometry
  // ---------------------------------------------------------------
  localparam int KWI_NUM_PINS = 6;
  localparam int KWI_ADDR_W = 12;
  localparam int KWI_DATA_W = 32;

  // ---------------------------------------------------------------
  // register offsets (byte addresses, one aligned word each)
  // ---------------------------------------------------------------
  localparam logic [KWI_ADDR_W-1:0] KWI_OFF_STATUS_CTRL = 12'h000;
  localparam logic [KWI_ADDR_W-1:0] KWI_OFF_PIN_ENABLE = 12'h004;

  // ---------------------------------------------------------------
  // keypad_status_control_reg fields
  // ---------------------------------------------------------------
  localparam int KWI_SC_SENS_BIT = 0;
  localparam int KWI_SC_MASK_BIT = 1;
  localparam int KWI_SC_ACK_BIT = 2;
  localparam int KWI_SC_PEND_BIT = 3;
  localparam logic [7:0] KWI_SC_RESET = 8'h00;

  // ---------------------------------------------------------------
  // keypad_pin_enable_reg fields
  // ---------------------------------------------------------------
  localparam int KWI_PE_AWU_BIT = 6;
  localparam logic [7:0] KWI_PE_RESET = 8'h00;

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  // word-aligned address match, low two bits ignored
  function automatic logic kwi_hit(
    input logic [KWI_ADDR_W-1:0] addr,
    input logic [KWI_ADDR_W-1:0] off
  );
    kwi_hit = (addr[KWI_ADDR_W-1:2] == off[KWI_ADDR_W-1:2]);
  endfunction : kwi_hit

endpackage : kwi_pkg

// ---- logic/kwi_sync.sv ----
// two-flop synchroniser for the keypad pin levels
module kwi_sync #(
  parameter int WIDTH = kwi_pkg::KWI_NUM_PINS
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  // ---------------------------------------------------------------
  // synchroniser stages
  // ---------------------------------------------------------------
  logic [WIDTH-1:0] meta;

  // idle pins sit high on their pullups, so reset to ones
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta <= '1;
      sync_out <= '1;
    end else begin
      meta <= async_in;
      sync_out <= meta;
    end
  end

endmodule : kwi_sync

// ---- logic/kwi_top.sv ----
// keypad wake interrupt unit with apb register slave
// What this block does
// - six pins, one enable bit each
// - enabled pin turns its pullup on
// - latch when enabled input falls from all-high
// - edge mode ignores fall while another low
// - level mode holds request while any low
// - level clear needs acknowledge and all high
// - vector fetch or ack write acknowledges
// - falling edge after acknowledge latches again
// - unmasked pending request goes to cpu
// - wake request cleared by ack write only
// - edge mode acknowledge clears immediately
// - reset clears request and sensitivity bit
// - pending flag readable, unmasked, reset clears
// - enable forces input; read needs direction 0
// - mask bit suppresses cpu requests
// - ack bit write-only, reads zero
// - status bits seven to four read zero
// - sensitivity bit covers pins and wake
// - active in wait and stop, wakes cpu
// - break blocks ack write unless clear enabled
// - reset clears all pin enables
//
// Chosen here: register access over APB and the register offsets.
module kwi_top #(
  parameter int NUM_PINS = kwi_pkg::KWI_NUM_PINS,
  parameter int ADDR_W = kwi_pkg::KWI_ADDR_W
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic pready,
  output logic [31:0] prdata,
  output logic pslverr,
  input wire logic [NUM_PINS-1:0] pin_level,
  input wire logic [NUM_PINS-1:0] port_direction,
  input wire logic [NUM_PINS-1:0] port_pullup_enable,
  input wire logic vector_fetch,
  input wire logic auto_wake_request,
  input wire logic break_state,
  input wire logic break_clear_enable,
  output logic [NUM_PINS-1:0] pin_pullup_on,
  output logic [NUM_PINS-1:0] pin_force_input,
  output logic [NUM_PINS-1:0] pin_read_enable,
  output logic auto_wake_enable,
  output logic keypad_irq,
  output logic wake_request
);

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  logic [NUM_PINS-1:0] pin_enable_bits;
  logic trigger_sensitivity_sel;
  logic request_mask;
  logic kb_req;
  logic ack_pend;
  logic aw_req;
  logic aw_in_q;
  logic any_low_q;
  logic [NUM_PINS-1:0] pin_sync;

  // ---------------------------------------------------------------
  // pin synchronisation
  // ---------------------------------------------------------------
  // pads change with no relation to pclk; keep detection clean
  kwi_sync #(
    .WIDTH(NUM_PINS)
  ) u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .async_in(pin_level),
    .sync_out(pin_sync)
  );

  // ---------------------------------------------------------------
  // apb decode
  // ---------------------------------------------------------------
  wire hit_sc;
  wire hit_pe;
  wire mapped;
  wire access;
  wire wr_en;
  wire wr_sc;
  wire wr_pe;
  wire rd_setup;

  // zero wait states: prdata is loaded during setup
  assign hit_sc = kwi_pkg::kwi_hit(paddr, kwi_pkg::KWI_OFF_STATUS_CTRL);
  assign hit_pe = kwi_pkg::kwi_hit(paddr, kwi_pkg::KWI_OFF_PIN_ENABLE);
  assign mapped = hit_sc | hit_pe;
  assign access = psel & penable;
  assign pready = 1'b1;
  assign pslverr = access & ~mapped;
  // all fields live in byte lane 0
  assign wr_en = access & pwrite & mapped & pstrb[0];
  assign wr_sc = wr_en & hit_sc;
  assign wr_pe = wr_en & hit_pe;
  assign rd_setup = psel & ~penable & ~pwrite;

  // ---------------------------------------------------------------
  // acknowledge sources
  // ---------------------------------------------------------------
  wire ack_bit;
  wire ack_allowed;
  wire sw_ack;
  wire kb_ack;

  // break state blocks the ack write unless clearing is enabled; vector fetch still clears
  assign ack_bit = pwdata[kwi_pkg::KWI_SC_ACK_BIT];
  assign ack_allowed = ~break_state | break_clear_enable;
  assign sw_ack = wr_sc & ack_bit & ack_allowed;
  assign kb_ack = sw_ack | vector_fetch;

  // ---------------------------------------------------------------
  // keypad request detection
  // ---------------------------------------------------------------
  wire [NUM_PINS-1:0] low_enabled;
  wire any_low;
  wire kb_edge;
  wire kb_clear;
  wire next_kb_req;
  wire next_ack_pend;

  // only enabled pins take part; a low on a disabled pin is ignored
  assign low_enabled = pin_enable_bits & ~pin_sync;
  assign any_low = |low_enabled;
  // fall counts only when every enabled input was high before
  assign kb_edge = any_low & ~any_low_q;
  // level mode waits for all inputs high, ack may come first
  assign kb_clear = trigger_sensitivity_sel ?
                    ((kb_ack | ack_pend) & ~any_low) :
                    kb_ack;
  // set wins over a clear in the same cycle; level mode also sets
  // from a plain low, so switching to level with a key held still
  // raises the request
  assign next_kb_req = kb_edge | (trigger_sensitivity_sel & any_low) |
                       (kb_req & ~kb_clear);
  assign next_ack_pend = ~kb_edge & kb_req & ~kb_clear &
                         (ack_pend | kb_ack);

  // ---------------------------------------------------------------
  // auto wake request path
  // ---------------------------------------------------------------
  wire aw_edge;
  wire aw_clear;
  wire next_aw_req;

  // wake source sits on pclk already, no synchroniser needed
  assign aw_edge = auto_wake_request & ~aw_in_q;
  // vector fetch never clears it; level mode needs input gone
  assign aw_clear = sw_ack &
                    (~trigger_sensitivity_sel | ~auto_wake_request);
  // level mode treats a standing wake input like a held key
  assign next_aw_req = aw_edge |
                       (trigger_sensitivity_sel & auto_wake_request) |
                       (aw_req & ~aw_clear);

  // ---------------------------------------------------------------
  // request latches
  // ---------------------------------------------------------------
  // no clock gating here so the latch runs in wait and stop
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      kb_req <= 1'b0;
      ack_pend <= 1'b0;
      aw_req <= 1'b0;
      aw_in_q <= 1'b0;
      any_low_q <= 1'b0;
    end else begin
      kb_req <= next_kb_req;
      ack_pend <= next_ack_pend;
      aw_req <= next_aw_req;
      aw_in_q <= auto_wake_request;
      any_low_q <= any_low;
    end
  end

  // ---------------------------------------------------------------
  // control registers
  // ---------------------------------------------------------------
  // mode and mask share the ack write; ack itself is not stored
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      trigger_sensitivity_sel <= kwi_pkg::KWI_SC_RESET[
        kwi_pkg::KWI_SC_SENS_BIT];
      request_mask <= kwi_pkg::KWI_SC_RESET[
        kwi_pkg::KWI_SC_MASK_BIT];
    end else if (wr_sc) begin
      trigger_sensitivity_sel <= pwdata[kwi_pkg::KWI_SC_SENS_BIT];
      request_mask <= pwdata[kwi_pkg::KWI_SC_MASK_BIT];
    end
  end

  // pin enables and the wake enable bit
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_enable_bits <= kwi_pkg::KWI_PE_RESET[NUM_PINS-1:0];
      auto_wake_enable <= kwi_pkg::KWI_PE_RESET[
        kwi_pkg::KWI_PE_AWU_BIT];
    end else if (wr_pe) begin
      pin_enable_bits <= pwdata[NUM_PINS-1:0];
      auto_wake_enable <= pwdata[kwi_pkg::KWI_PE_AWU_BIT];
    end
  end

  // ---------------------------------------------------------------
  // read data
  // ---------------------------------------------------------------
  wire pending_flag;
  wire [7:0] sc_byte;
  wire [7:0] pe_byte;
  wire [31:0] next_prdata;

  // pending flag ignores the mask so polling works
  assign pending_flag = kb_req | aw_req;
  // ack reads zero, upper nibble reads zero
  assign sc_byte = {4'h0, pending_flag, 1'b0, request_mask,
                    trigger_sensitivity_sel};
  assign pe_byte = 8'(pin_enable_bits) |
                   (8'(auto_wake_enable) << kwi_pkg::KWI_PE_AWU_BIT);
  assign next_prdata = hit_sc ? {24'h000000, sc_byte} :
                       hit_pe ? {24'h000000, pe_byte} :
                       32'h00000000;

  // captured in setup so the access phase answers at once
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
    end else if (rd_setup) begin
      prdata <= next_prdata;
    end
  end

  // ---------------------------------------------------------------
  // outputs to cpu and port
  // ---------------------------------------------------------------
  // one request line serves both interrupt and wakeup
  assign keypad_irq = pending_flag & ~request_mask;
  assign wake_request = pending_flag & ~request_mask;
  // enable overrides the port pullup setting
  assign pin_pullup_on = pin_enable_bits | port_pullup_enable;
  // enable overrides direction, but reads still need direction 0
  assign pin_force_input = pin_enable_bits;
  assign pin_read_enable = ~port_direction;

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  property p_edge_sets;
    @(posedge pclk) disable iff (!presetn)
    (any_low && !any_low_q) |=> kb_req;
  endproperty
  a_edge_sets: assert property (p_edge_sets)
    else $error("falling edge did not latch request");

  property p_edge_blocked;
    @(posedge pclk) disable iff (!presetn)
    (!trigger_sensitivity_sel && any_low_q && !kb_req) |=> !kb_req;
  endproperty
  a_edge_blocked: assert property (p_edge_blocked)
    else $error("request latched while an input was low");

  property p_level_hold;
    @(posedge pclk) disable iff (!presetn)
    (trigger_sensitivity_sel && kb_req && any_low) |=> kb_req;
  endproperty
  a_level_hold: assert property (p_level_hold)
    else $error("level request dropped while input low");

  property p_level_set;
    @(posedge pclk) disable iff (!presetn)
    (trigger_sensitivity_sel && any_low) |=> kb_req;
  endproperty
  a_level_set: assert property (p_level_set)
    else $error("low input in level mode left no request");

  property p_level_clear;
    @(posedge pclk) disable iff (!presetn)
    (trigger_sensitivity_sel && kb_req && !any_low && !any_low_q &&
     (ack_pend || kb_ack)) |=> !kb_req;
  endproperty
  a_level_clear: assert property (p_level_clear)
    else $error("level request not cleared after ack and high");

  property p_edge_ack;
    @(posedge pclk) disable iff (!presetn)
    (!trigger_sensitivity_sel && kb_ack && !kb_edge) |=> !kb_req;
  endproperty
  a_edge_ack: assert property (p_edge_ack)
    else $error("edge mode ack did not clear request");

  property p_ack_then_edge;
    @(posedge pclk) disable iff (!presetn)
    (kb_ack && kb_edge) |=> kb_req;
  endproperty
  a_ack_then_edge: assert property (p_ack_then_edge)
    else $error("new edge lost against acknowledge");

  property p_fetch_keeps_wake;
    @(posedge pclk) disable iff (!presetn)
    (aw_req && vector_fetch && !wr_sc) |=> aw_req;
  endproperty
  a_fetch_keeps_wake: assert property (p_fetch_keeps_wake)
    else $error("vector fetch cleared wake request");

  property p_mask;
    @(posedge pclk) disable iff (!presetn)
    $rose(request_mask) |-> !keypad_irq && !wake_request;
  endproperty
  a_mask: assert property (p_mask)
    else $error("masked request reached cpu");

  property p_irq_follows;
    @(posedge pclk) disable iff (!presetn)
    (kb_edge && !request_mask && !wr_sc) |=> keypad_irq;
  endproperty
  a_irq_follows: assert property (p_irq_follows)
    else $error("unmasked request not presented");

  property p_break_lock;
    @(posedge pclk) disable iff (!presetn)
    (break_state && !break_clear_enable && !vector_fetch &&
     kb_req && !trigger_sensitivity_sel) |=> kb_req;
  endproperty
  a_break_lock: assert property (p_break_lock)
    else $error("ack write cleared latch during break");

  property p_ack_reads_zero;
    @(posedge pclk) disable iff (!presetn)
    (rd_setup && hit_sc) |=>
      (prdata[kwi_pkg::KWI_SC_ACK_BIT] == 1'b0) &&
      (prdata[7:4] == 4'h0);
  endproperty
  a_ack_reads_zero: assert property (p_ack_reads_zero)
    else $error("ack or unused bits read nonzero");

  property p_pend_flag;
    @(posedge pclk) disable iff (!presetn)
    (rd_setup && hit_sc && (kb_req || aw_req)) |=>
      prdata[kwi_pkg::KWI_SC_PEND_BIT];
  endproperty
  a_pend_flag: assert property (p_pend_flag)
    else $error("pending flag not readable");

endmodule : kwi_top

// ---- test/kwi_keys.sv ----
// key switch model driving the keypad pads
module kwi_keys #(
  parameter int N = kwi_pkg::KWI_NUM_PINS
) (
  input wire logic pclk,
  input wire logic [N-1:0] press,
  input wire logic [N-1:0] pullup_on,
  output logic [N-1:0] pin_level
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [N-1:0] last = '1;
  // an open pad without pullup flips each cycle, so no settled value
  // is trusted; own phase register so the pad never turns unknown
  always_ff @(posedge pclk) begin
    last <= ~last;
  end
  // a pressed key shorts its pad to ground
  always_comb begin
    for (int i = 0; i < N; i++) begin
      pin_level[i] = press[i] ? 1'b0 : (pullup_on[i] ? 1'b1 : last[i]);
    end
  end
endmodule : kwi_keys

// ---- test/kwi_top_tb.sv ----
// self-checking bench for the keypad wake interrupt unit
`define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin \
  error_cnt++; $display("unexpected %s exp %h got %h", n, e, g); end end
module kwi_top_tb;
  timeunit 1ns;
  timeprecision 100ps;
  // ---------------------------------------------------------------
  // signals
  // ---------------------------------------------------------------
  localparam logic [11:0] sc_a = kwi_pkg::KWI_OFF_STATUS_CTRL;
  localparam logic [11:0] pe_a = kwi_pkg::KWI_OFF_PIN_ENABLE;
  logic pclk, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, rd;
  logic [3:0] pstrb = 4'hF;
  logic pready, pslverr, err, auto_wake_enable, keypad_irq, wake_request;
  logic [5:0] pin_level, port_direction, port_pullup_enable, press = '0;
  logic [5:0] pin_pullup_on, pin_force_input, pin_read_enable;
  logic vector_fetch = 1'b0, auto_wake_request = 1'b0;
  logic break_state = 1'b0, break_clear_enable = 1'b0;
  int error_cnt = 0, comparisons = 0, i, j, rnd;

  kwi_top dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(pstrb), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .pin_level(pin_level), .port_direction(port_direction),
    .port_pullup_enable(port_pullup_enable), .vector_fetch(vector_fetch),
    .auto_wake_request(auto_wake_request), .break_state(break_state),
    .break_clear_enable(break_clear_enable), .pin_pullup_on(pin_pullup_on),
    .pin_force_input(pin_force_input), .pin_read_enable(pin_read_enable),
    .auto_wake_enable(auto_wake_enable), .keypad_irq(keypad_irq),
    .wake_request(wake_request));
  kwi_keys keys (.pclk(pclk), .press(press), .pullup_on(pin_pullup_on),
    .pin_level(pin_level));

  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  function automatic logic [31:0] exp_sc(input logic md, input logic mk,
                                         input logic pd);
    exp_sc = 32'h0;
    exp_sc[kwi_pkg::KWI_SC_SENS_BIT] = md;
    exp_sc[kwi_pkg::KWI_SC_MASK_BIT] = mk;
    exp_sc[kwi_pkg::KWI_SC_PEND_BIT] = pd;
  endfunction : exp_sc
  // master waits for pready, never assumes a latency
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 64);
    if (n >= 64) begin
      error_cnt++;
      results();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic tick(input int n);
    repeat (n) @(posedge pclk);
    #1;
  endtask : tick
  task automatic sc_is(input logic [31:0] e);
    apb(1'b0, sc_a, 32'h0);
    `CHK("status", e, rd)
  endtask : sc_is
  task automatic pe_is(input logic [31:0] e);
    apb(1'b0, pe_a, 32'h0);
    `CHK("enable", e, rd)
  endtask : pe_is
  // leaves five edges for the two-flop path plus the latch
  task automatic irq_is(input logic e);
    tick(5);
    `CHK("irq", e, keypad_irq)
    `CHK("wake", e, wake_request)
  endtask : irq_is
  task automatic key(input int k, input logic v);
    @(posedge pclk);
    press[k] <= v;
  endtask : key
  task automatic fetch();
    @(posedge pclk);
    vector_fetch <= 1'b1;
    @(posedge pclk);
    vector_fetch <= 1'b0;
  endtask : fetch
  task automatic do_reset();
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
  endtask : do_reset
  // enabling can fake an edge, so the mask covers it until acked
  task automatic setup_unit(input logic md);
    apb(1'b1, sc_a, 32'h02);
    apb(1'b1, pe_a, 32'hFF);
    tick(4);
    apb(1'b1, sc_a, 32'h06);
    apb(1'b1, sc_a, {31'h0, md});
  endtask : setup_unit
  task automatic results();
    $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : results
  // ---------------------------------------------------------------
  // tests
  // ---------------------------------------------------------------
  initial begin
    repeat (20000) @(posedge pclk);
    error_cnt++;
    results();
  end
  initial begin
    rnd = $urandom(32);
    @(posedge pclk);
    port_direction <= 6'($urandom);
    port_pullup_enable <= 6'($urandom);
    repeat (11) @(posedge pclk);
    presetn <= 1'b1;
    tick(1);
    `CHK("force", 6'h00, pin_force_input)
    `CHK("pullup", port_pullup_enable, pin_pullup_on)
    `CHK("readen", ~port_direction, pin_read_enable)
    sc_is(exp_sc(1'b0, 1'b0, 1'b0));
    pe_is(32'h0);
    $display("test reset done");
    setup_unit(1'b0);
    pe_is(32'h7F);
    `CHK("force", 6'h3F, pin_force_input)
    `CHK("pullup", 6'h3F, pin_pullup_on)
    `CHK("awe", 1'b1, auto_wake_enable)
    apb(1'b1, sc_a, 32'hF7);
    sc_is(exp_sc(1'b1, 1'b1, 1'b0));
    @(posedge pclk);
    pstrb <= 4'h0;
    apb(1'b1, sc_a, 32'h00);
    pstrb <= 4'hF;
    sc_is(exp_sc(1'b1, 1'b1, 1'b0));
    apb(1'b0, 12'h008, 32'h0);
    `CHK("slverr", 1'b1, err)
    `CHK("unmapped", 32'h0, rd)
    apb(1'b1, sc_a, 32'h00);
    $display("test registers done");
    // edge mode, random pin pairs
    key(0, 1'b1);
    tick(2);
    `CHK("sync", 1'b0, keypad_irq)
    tick(3);
    `CHK("irq", 1'b1, keypad_irq)
    fetch();
    key(0, 1'b0);
    for (int k = 0; k < 4; k++) begin
      i = $urandom_range(5, 0);
      j = (i + 1 + $urandom_range(4, 0)) % 6;
      key(i, 1'b1);
      irq_is(1'b1);
      sc_is(exp_sc(1'b0, 1'b0, 1'b1));
      key(j, 1'b1);
      apb(1'b1, sc_a, 32'h04);
      irq_is(1'b0);
      key(i, 1'b0);
      tick(4);
      key(i, 1'b1);
      irq_is(1'b0);
      @(posedge pclk);
      press <= '0;
      irq_is(1'b0);
      key(i, 1'b1);
      irq_is(1'b1);
      fetch();
      irq_is(1'b0);
      key(i, 1'b0);
    end
    $display("test edge done");
    apb(1'b1, sc_a, 32'h02);
    key(i, 1'b1);
    irq_is(1'b0);
    sc_is(exp_sc(1'b0, 1'b1, 1'b1));
    key(i, 1'b0);
    apb(1'b1, sc_a, 32'h04);
    sc_is(exp_sc(1'b0, 1'b0, 1'b0));
    $display("test mask done");
    key(j, 1'b1);
    irq_is(1'b1);
    apb(1'b1, sc_a, 32'h04);
    irq_is(1'b0);
    // switching to level mode with the key still held raises it again
    apb(1'b1, sc_a, 32'h01);
    irq_is(1'b1);
    apb(1'b1, sc_a, 32'h05);
    irq_is(1'b1);
    key(j, 1'b0);
    irq_is(1'b0);
    key(j, 1'b1);
    tick(4);
    key(j, 1'b0);
    irq_is(1'b1);
    fetch();
    irq_is(1'b0);
    $display("test level done");
    @(posedge pclk);
    auto_wake_request <= 1'b1;
    irq_is(1'b1);
    fetch();
    apb(1'b1, sc_a, 32'h05);
    irq_is(1'b1);
    @(posedge pclk);
    auto_wake_request <= 1'b0;
    fetch();
    irq_is(1'b1);
    apb(1'b1, sc_a, 32'h05);
    irq_is(1'b0);
    $display("test wake done");
    apb(1'b1, sc_a, 32'h00);
    @(posedge pclk);
    break_state <= 1'b1;
    key(i, 1'b1);
    irq_is(1'b1);
    apb(1'b1, sc_a, 32'h04);
    irq_is(1'b1);
    @(posedge pclk);
    break_clear_enable <= 1'b1;
    apb(1'b1, sc_a, 32'h04);
    irq_is(1'b0);
    @(posedge pclk);
    break_state <= 1'b0;
    break_clear_enable <= 1'b0;
    irq_is(1'b0);
    key(i, 1'b0);
    $display("test break done");
    apb(1'b1, sc_a, 32'h01);
    key(i, 1'b1);
    irq_is(1'b1);
    do_reset();
    irq_is(1'b0);
    sc_is(exp_sc(1'b0, 1'b0, 1'b0));
    pe_is(32'h0);
    $display("test reset in run done");
    results();
  end
endmodule : kwi_top_tb
